// file: cursor_pkg.sv
// shared constants for the hardware cursor overlay
package cursor_pkg;
	localparam logic [7:0] IDX_FG_COLOR   = 8'h0e;
	localparam logic [7:0] IDX_BG_COLOR   = 8'h0f;
	localparam logic [7:0] IDX_UNLOCK     = 8'h38;
	localparam logic [7:0] IDX_MODE       = 8'h45;
	localparam logic [7:0] IDX_X_HIGH     = 8'h46;
	localparam logic [7:0] IDX_X_LOW      = 8'h47;
	localparam logic [7:0] IDX_Y_HIGH     = 8'h48;
	localparam logic [7:0] IDX_Y_LOW      = 8'h49;
	localparam logic [7:0] IDX_FG_STACK   = 8'h4a;
	localparam logic [7:0] IDX_BG_STACK   = 8'h4b;
	localparam logic [7:0] IDX_ROW_FIRST  = 8'h4c;
	localparam logic [7:0] IDX_ROW_SECOND = 8'h4d;
	localparam logic [7:0] IDX_X_OFFSET   = 8'h4e;
	localparam logic [7:0] IDX_Y_OFFSET   = 8'h4f;
	localparam logic [7:0] UNLOCK_KEY     = 8'ha0;
	localparam logic [7:0] LOCK_KEY       = 8'h00;
	localparam int         MODE_ENABLE    = 0;
	localparam int         MODE_ALT_TABLE = 1;
	localparam int         MODE_ZOOM2     = 2;
	localparam int         MODE_ZOOM3     = 3;
	localparam int         CURSOR_SIZE    = 64;
	localparam int         MASK_WORDS     = 256;
	localparam int         STACK_DEPTH    = 3;
	localparam logic [10:0] SCREEN_W      = 11'd1024;
	localparam logic [10:0] SCREEN_H      = 11'd768;
	localparam logic [7:0] RESET_BYTE     = 8'h00;
	localparam logic [5:0] SPIN_CYCLES    = 6'd2;
	localparam int         PIX_W          = 24;
	// host port addresses: index port and data port
	localparam logic [1:0] PORT_INDEX     = 2'h0;
	localparam logic [1:0] PORT_DATA      = 2'h1;
	localparam logic [31:0] AXI_CMD       = 32'h00;
	localparam logic [31:0] AXI_STATUS    = 32'h04;
	localparam logic [31:0] AXI_RDATA     = 32'h08;
	localparam logic [1:0] RESP_OKAY      = 2'b00;
	localparam logic [1:0] RESP_SLVERR    = 2'b10;
endpackage : cursor_pkg

// file: cursor_if.sv
// link between the cursor overlay and the host driving its byte ports
`timescale 1ns/10ps
`default_nettype none
interface cursor_if;
	logic       io_stb;
	logic       io_we;
	logic [1:0] io_port;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       io_ack;
	modport dev  (input io_stb, io_we, io_port, io_wdata, output io_rdata, io_ack);
	modport host (output io_stb, io_we, io_port, io_wdata, input io_rdata, io_ack);
endinterface : cursor_if
`default_nettype wire

// file: cursor_overlay.sv
// cursor overlay device: indexed registers, mask fetch and pixel mixing
//
// Function
// - cursor shown only in enhanced mode
// - cursor is 64x64 from off-screen memory
// - two 512-byte masks: AND then XOR
// - default table: bg, fg, screen, inverted screen
// - alternate table: screen when AND zero
// - colour indices at 0EH and 0FH
// - true-colour stacks 4AH/4BH, three bytes each
// - mode register read clears stack pointers
// - stack writes fill low byte first
// - mode bit 0 enables cursor
// - control writes need unlock key A0H
// - coordinates 0 to 2047, partial display
// - coordinate high bits 10:8, low 7:0
// - Y offset hides top rows at edge
// - X offset hides left columns at edge
// - clip at right/bottom, hidden off-screen
// - pattern row from 4CH/4DH, X zero
// - memory words alternate AND and XOR
// - pattern rectangle 1024x1 or variants
// - zoom bits 2,3 use colour stacks
// - byte access via index/data ports
// - software pads small shapes transparently
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module cursor_overlay
	import cursor_pkg::*;
#(
	parameter int MEM_AW = 20
) (
	input  wire logic                CLK,
	input  wire logic                ARST_N,
	cursor_if.dev                    HOST,
	input  wire logic                ENHANCED_MODE,
	input  wire logic [1:0]          FOUR_PLANE_CFG,
	input  wire logic                LINE_START,
	input  wire logic [10:0]         RASTER_X,
	input  wire logic [10:0]         RASTER_Y,
	input  wire logic                PIX_VALID,
	input  wire logic [PIX_W-1:0]    PIX_IN,
	output logic                     PIX_OUT_VALID,
	output logic [PIX_W-1:0]         PIX_OUT,
	output logic                     MEM_REQ,
	output logic [MEM_AW-1:0]        MEM_ADDR,
	input  wire logic                MEM_ACK,
	input  wire logic [15:0]         MEM_DATA,
	output logic                     CURSOR_ACTIVE
);
	import cursor_pkg::*;

	typedef enum {FETCH_IDLE, FETCH_AND, FETCH_XOR} fetch_t;

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [7:0]  index_q;
	logic [7:0]  unlock_q;
	logic [7:0]  fg_idx_q, bg_idx_q, mode_q, row_lo_q, row_hi_q;
	logic [5:0]  xoff_q, yoff_q;
	logic [10:0] x_pend_q, y_pend_q, x_q, y_q;
	logic [7:0]  fg_stack_q [STACK_DEPTH];
	logic [7:0]  bg_stack_q [STACK_DEPTH];
	logic [1:0]  fg_ptr_q, bg_ptr_q;
	logic [7:0]  rdata_q;
	logic        ack_q;
	logic        unlocked;
	logic        data_wr, data_rd;

	assign unlocked = (unlock_q == UNLOCK_KEY);
	assign data_wr  = HOST.io_stb && HOST.io_we && HOST.io_port == PORT_DATA;
	assign data_rd  = HOST.io_stb && !HOST.io_we && HOST.io_port == PORT_DATA;

	function automatic logic [1:0] ptr_next(input logic [1:0] p);
		ptr_next = (p == 2'(STACK_DEPTH - 1)) ? p : p + 2'd1;
	endfunction : ptr_next

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			index_q <= RESET_BYTE;
		end else if (HOST.io_stb && HOST.io_we && HOST.io_port == PORT_INDEX) begin
			index_q <= HOST.io_wdata;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			unlock_q <= RESET_BYTE;
			fg_idx_q <= RESET_BYTE;
			bg_idx_q <= RESET_BYTE;
			mode_q   <= RESET_BYTE;
			row_lo_q <= RESET_BYTE;
			row_hi_q <= RESET_BYTE;
			xoff_q   <= '0;
			yoff_q   <= '0;
			x_pend_q <= '0;
			y_pend_q <= '0;
			x_q      <= '0;
			y_q      <= '0;
		end else if (data_wr) begin
			if (index_q == IDX_UNLOCK) begin
				unlock_q <= HOST.io_wdata;
			end else if (unlocked) begin
				case (index_q)
					IDX_FG_COLOR:   fg_idx_q <= HOST.io_wdata;
					IDX_BG_COLOR:   bg_idx_q <= HOST.io_wdata;
					IDX_MODE:       mode_q <= HOST.io_wdata;
					IDX_ROW_FIRST:  row_lo_q <= HOST.io_wdata;
					IDX_ROW_SECOND: row_hi_q <= HOST.io_wdata;
					IDX_X_OFFSET:   xoff_q <= HOST.io_wdata[5:0];
					IDX_Y_OFFSET:   yoff_q <= HOST.io_wdata[5:0];
					IDX_X_HIGH:     x_pend_q[10:8] <= HOST.io_wdata[2:0];
					IDX_X_LOW:      x_pend_q[7:0] <= HOST.io_wdata;
					IDX_Y_LOW:      y_pend_q[7:0] <= HOST.io_wdata;
					IDX_Y_HIGH: begin
						// commit whole pair so no frame sees half a move
						y_q <= {HOST.io_wdata[2:0], y_pend_q[7:0]};
						x_q <= x_pend_q;
						y_pend_q[10:8] <= HOST.io_wdata[2:0];
					end
					default: ;
				endcase
			end
		end
	end

	// stacks: pointer advances per write up to the third byte and holds there, cleared by mode read
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			fg_ptr_q <= '0;
			bg_ptr_q <= '0;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				fg_stack_q[i] <= RESET_BYTE;
				bg_stack_q[i] <= RESET_BYTE;
			end
		end else if (data_rd && index_q == IDX_MODE) begin
			fg_ptr_q <= '0;
			bg_ptr_q <= '0;
		end else if (data_wr && unlocked) begin
			if (index_q == IDX_FG_STACK) begin
				fg_stack_q[fg_ptr_q] <= HOST.io_wdata;
				fg_ptr_q <= ptr_next(fg_ptr_q);
			end else if (index_q == IDX_BG_STACK) begin
				bg_stack_q[bg_ptr_q] <= HOST.io_wdata;
				bg_ptr_q <= ptr_next(bg_ptr_q);
			end
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_q <= RESET_BYTE;
			ack_q   <= 1'b0;
		end else begin
			ack_q <= HOST.io_stb;
			if (HOST.io_stb && !HOST.io_we) begin
				case (HOST.io_port == PORT_INDEX ? 8'hff : index_q)
					8'hff:          rdata_q <= index_q;
					IDX_UNLOCK:     rdata_q <= unlock_q;
					IDX_FG_COLOR:   rdata_q <= fg_idx_q;
					IDX_BG_COLOR:   rdata_q <= bg_idx_q;
					IDX_MODE:       rdata_q <= mode_q;
					IDX_ROW_FIRST:  rdata_q <= row_lo_q;
					IDX_ROW_SECOND: rdata_q <= row_hi_q;
					IDX_X_OFFSET:   rdata_q <= {2'b00, xoff_q};
					IDX_Y_OFFSET:   rdata_q <= {2'b00, yoff_q};
					IDX_X_HIGH:     rdata_q <= {5'b0, x_pend_q[10:8]};
					IDX_X_LOW:      rdata_q <= x_pend_q[7:0];
					IDX_Y_HIGH:     rdata_q <= {5'b0, y_pend_q[10:8]};
					IDX_Y_LOW:      rdata_q <= y_pend_q[7:0];
					IDX_FG_STACK:   rdata_q <= fg_stack_q[fg_ptr_q];
					IDX_BG_STACK:   rdata_q <= bg_stack_q[bg_ptr_q];
					default:        rdata_q <= RESET_BYTE;
				endcase
			end
		end
	end
	assign HOST.io_rdata = rdata_q;
	assign HOST.io_ack   = ack_q;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	logic        shown;
	logic [1:0]  zoom;
	logic [11:0] dx, dy;
	logic [11:0] col_full, row_full;
	logic        in_x, in_y, in_box;
	logic [5:0]  col, row;

	assign shown = ENHANCED_MODE && mode_q[MODE_ENABLE];
	assign zoom  = mode_q[MODE_ZOOM3] ? 2'd3 : (mode_q[MODE_ZOOM2] ? 2'd2 : 2'd1);
	assign dx    = {1'b0, RASTER_X} - {1'b0, x_q};
	assign dy    = {1'b0, RASTER_Y} - {1'b0, y_q};
	// divide by zoom first, then skip the offset columns/rows
	assign col_full = 12'(dx / zoom) + {6'b0, xoff_q};
	assign row_full = 12'(dy / zoom) + {6'b0, yoff_q};
	assign in_x  = RASTER_X >= x_q && col_full < 12'(CURSOR_SIZE) && RASTER_X < SCREEN_W;
	assign in_y  = RASTER_Y >= y_q && row_full < 12'(CURSOR_SIZE) && RASTER_Y < SCREEN_H;
	assign in_box = shown && in_x && in_y;
	assign col   = col_full[5:0];
	assign row   = row_full[5:0];

	// ----------------------------------------------------------------
	// line fetch: one row = 4 AND words and 4 XOR words, interleaved
	// ----------------------------------------------------------------
	fetch_t      fstate_q;
	logic [1:0]  fword_q;
	logic [15:0] and_line_q [4];
	logic [15:0] xor_line_q [4];
	logic [5:0]  frow_q;
	logic [MEM_AW-1:0] base;
	logic [MEM_AW-1:0] row_pitch;

	// pattern occupies 1024 wide row(s); 1 MB four-plane uses 2048 wide
	assign row_pitch = (FOUR_PLANE_CFG == 2'd2) ? MEM_AW'(2048) : MEM_AW'(1024);
	assign base = MEM_AW'({row_hi_q, row_lo_q}) * row_pitch;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			fstate_q <= FETCH_IDLE;
			fword_q  <= '0;
			frow_q   <= '0;
			MEM_REQ  <= 1'b0;
			MEM_ADDR <= '0;
			for (int i = 0; i < 4; i++) begin
				and_line_q[i] <= '1;
				xor_line_q[i] <= '0;
			end
		end else begin
			case (fstate_q)
				FETCH_IDLE: if (LINE_START && shown) begin
					// next raster line's cursor row
					frow_q   <= 6'(((RASTER_Y + 11'd1 - y_q) / 11'(zoom)) + 11'(yoff_q));
					fword_q  <= '0;
					fstate_q <= FETCH_AND;
					MEM_REQ  <= 1'b1;
					MEM_ADDR <= base + MEM_AW'({(RASTER_Y + 11'd1 - y_q) / 11'(zoom)
						+ 11'(yoff_q), 3'b000}) * MEM_AW'(2);
				end
				FETCH_AND: if (MEM_ACK) begin
					and_line_q[fword_q] <= MEM_DATA;
					MEM_ADDR <= MEM_ADDR + MEM_AW'(2);
					fstate_q <= FETCH_XOR;
				end
				FETCH_XOR: if (MEM_ACK) begin
					xor_line_q[fword_q] <= MEM_DATA;
					MEM_ADDR <= MEM_ADDR + MEM_AW'(2);
					fword_q  <= fword_q + 2'd1;
					if (fword_q == 2'd3) begin
						MEM_REQ  <= 1'b0;
						fstate_q <= FETCH_IDLE;
					end else begin
						fstate_q <= FETCH_AND;
					end
				end
				default: fstate_q <= FETCH_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pixel mixing
	// ----------------------------------------------------------------
	logic              and_bit, xor_bit;
	logic [PIX_W-1:0]  fg_pix, bg_pix, mixed;
	logic              use_stack;

	assign and_bit = and_line_q[col[5:4]][4'd15 - col[3:0]];
	assign xor_bit = xor_line_q[col[5:4]][4'd15 - col[3:0]];
	assign use_stack = mode_q[MODE_ZOOM2] || mode_q[MODE_ZOOM3] || (PIX_W > 8 && 1'b0);
	assign fg_pix = use_stack ? {fg_stack_q[2], fg_stack_q[1], fg_stack_q[0]}
		: PIX_W'(fg_idx_q);
	assign bg_pix = use_stack ? {bg_stack_q[2], bg_stack_q[1], bg_stack_q[0]}
		: PIX_W'(bg_idx_q);

	always_comb begin
		mixed = PIX_IN;
		if (mode_q[MODE_ALT_TABLE]) begin
			if (and_bit) mixed = xor_bit ? fg_pix : bg_pix;
		end else begin
			case ({and_bit, xor_bit})
				2'b00:   mixed = bg_pix;
				2'b01:   mixed = fg_pix;
				2'b10:   mixed = PIX_IN;
				default: mixed = ~PIX_IN;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PIX_OUT       <= '0;
			PIX_OUT_VALID <= 1'b0;
			CURSOR_ACTIVE <= 1'b0;
		end else begin
			PIX_OUT_VALID <= PIX_VALID;
			PIX_OUT       <= in_box ? mixed : PIX_IN;
			CURSOR_ACTIVE <= PIX_VALID && in_box;
		end
	end
endmodule : cursor_overlay
`default_nettype wire

// file: cursor_host.sv
// host end: AXI4-Lite command registers turned into index/data byte cycles
`timescale 1ns/10ps
`default_nettype none
module cursor_host
	import cursor_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	cursor_if.host           DEV,
	input  wire logic [31:0] S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [31:0] S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY
);
	import cursor_pkg::*;

	typedef enum {H_IDLE, H_INDEX, H_DATA, H_WAIT} host_t;

	// ----------------------------------------------------------------
	// AXI write side; CMD word = {we[16], data[15:8], index[7:0]}
	// ----------------------------------------------------------------
	host_t       st_q;
	logic [16:0] cmd_q;
	logic [7:0]  rbyte_q;
	logic        aw_got_q, w_got_q;
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic        busy;

	assign busy = (st_q != H_IDLE);

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= RESP_OKAY;
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
		end else begin
			S_AXI_AWREADY <= !aw_got_q && !S_AXI_AWREADY && S_AXI_AWVALID && !S_AXI_BVALID;
			S_AXI_WREADY  <= !w_got_q && !S_AXI_WREADY && S_AXI_WVALID && !S_AXI_BVALID;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_got_q <= 1'b1;
				awaddr_q <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_got_q <= 1'b1;
				wdata_q <= S_AXI_WDATA;
			end
			if (aw_got_q && w_got_q && !S_AXI_BVALID && !busy) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= (awaddr_q == AXI_CMD) ? RESP_OKAY : RESP_SLVERR;
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// byte sequencer: index cycle, then data cycle
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_q        <= H_IDLE;
			cmd_q       <= '0;
			rbyte_q     <= RESET_BYTE;
			DEV.io_stb  <= 1'b0;
			DEV.io_we   <= 1'b0;
			DEV.io_port <= PORT_INDEX;
			DEV.io_wdata <= RESET_BYTE;
		end else begin
			DEV.io_stb <= 1'b0;
			case (st_q)
				H_IDLE: if (aw_got_q && w_got_q && !S_AXI_BVALID && awaddr_q == AXI_CMD
					&& S_AXI_WSTRB != 4'h0) begin
					// each command is one register byte: ordering is software's
					cmd_q        <= wdata_q[16:0];
					DEV.io_stb   <= 1'b1;
					DEV.io_we    <= 1'b1;
					DEV.io_port  <= PORT_INDEX;
					DEV.io_wdata <= wdata_q[7:0];
					st_q         <= H_INDEX;
				end
				H_INDEX: if (DEV.io_ack) begin
					DEV.io_stb   <= 1'b1;
					DEV.io_we    <= cmd_q[16];
					DEV.io_port  <= PORT_DATA;
					DEV.io_wdata <= cmd_q[15:8];
					st_q         <= H_DATA;
				end
				H_DATA: if (DEV.io_ack) begin
					st_q <= H_WAIT;
				end
				H_WAIT: begin
					rbyte_q <= DEV.io_rdata;
					st_q    <= H_IDLE;
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// AXI read side
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= '0;
			S_AXI_RRESP   <= RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= !S_AXI_ARREADY && S_AXI_ARVALID && !S_AXI_RVALID;
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP  <= RESP_OKAY;
				case (S_AXI_ARADDR)
					AXI_CMD:    S_AXI_RDATA <= {15'b0, cmd_q};
					AXI_STATUS: S_AXI_RDATA <= {31'b0, busy};
					AXI_RDATA:  S_AXI_RDATA <= {24'b0, rbyte_q};
					default: begin
						S_AXI_RDATA <= '0;
						S_AXI_RRESP <= RESP_SLVERR;
					end
				endcase
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end
endmodule : cursor_host
`default_nettype wire

// file: cursor_overlay_checker.sv
// concurrent checks on the host link and pixel path of the cursor overlay
`timescale 1ns/10ps
`default_nettype none
module cursor_overlay_checker (
	input wire logic                        CLK,
	input wire logic                        ARST_N,
	input wire logic                        io_stb,
	input wire logic [1:0]                  io_port,
	input wire logic                        io_ack,
	input wire logic                        ENHANCED_MODE,
	input wire logic                        PIX_VALID,
	input wire logic [cursor_pkg::PIX_W-1:0] PIX_IN,
	input wire logic                        PIX_OUT_VALID,
	input wire logic [cursor_pkg::PIX_W-1:0] PIX_OUT,
	input wire logic                        CURSOR_ACTIVE,
	input wire logic                        MEM_REQ,
	input wire logic                        MEM_ACK
);
	import cursor_pkg::*;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);
	// ----
	// byte link
	// ----
	sequence s_index_taken;
		io_stb && io_port == PORT_INDEX ##1 io_ack;
	endsequence
	a_ack_one_cycle: assert property (io_stb |=> io_ack)
		else $error("link ack missing after strobe");
	a_ack_has_cause: assert property (io_ack |-> $past(io_stb))
		else $error("link ack without strobe");
	a_stb_is_pulse: assert property (io_stb |=> !io_stb)
		else $error("link strobe longer than one cycle");
	a_data_follows: assert property (s_index_taken |-> ##[1:6] (io_stb && io_port == PORT_DATA))
		else $error("index cycle not followed by data cycle");
	// ----
	// pixel path and fetch
	// ----
	a_pix_latency: assert property (PIX_VALID |=> PIX_OUT_VALID)
		else $error("pixel output not one cycle after input");
	a_vga_passes: assert property (!ENHANCED_MODE && PIX_VALID |=> PIX_OUT == $past(PIX_IN))
		else $error("pixel altered outside enhanced mode");
	a_vga_no_cursor: assert property (!ENHANCED_MODE [*2] |-> !CURSOR_ACTIVE)
		else $error("cursor active outside enhanced mode");
	a_idle_passes: assert property (PIX_VALID ##1 !CURSOR_ACTIVE |-> PIX_OUT == $past(PIX_IN))
		else $error("pixel altered with cursor inactive");
	a_req_holds: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ)
		else $error("fetch request dropped before ack");
endmodule : cursor_overlay_checker
`default_nettype wire

// file: hardware_cursor_overlay_tb.sv
// self-checking bench: AXI host end driving the overlay, pixel and memory stimulus
`timescale 1ns/10ps
`default_nettype none
module hardware_cursor_overlay_tb;
	import cursor_pkg::*;
	logic             clk = 1'b0;
	logic             arst_n = 1'b0;
	logic             enh = 1'b1;
	logic             line_start = 1'b0;
	logic [10:0]      rx = '0;
	logic [10:0]      ry = '0;
	logic             pix_valid = 1'b0;
	logic [PIX_W-1:0] pix_in = '0;
	logic [PIX_W-1:0] pix_out;
	logic             pix_out_valid;
	logic             cur_act;
	logic             mem_req;
	logic             mem_ack = 1'b0;
	logic [19:0]      mem_addr;
	logic [15:0]      mem_data = '0;
	logic [15:0]      mem_word = '0;
	logic [31:0]      awaddr = '0, wdata = '0, araddr = '0, rdata, s;
	logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic             arvalid = 1'b0, rready = 1'b0;
	logic             awready, wready, bvalid, arready, rvalid;
	logic [1:0]       bresp, rresp;
	logic [34:0]      rd_q[$];
	logic [34:0]      re;
	logic [PIX_W-1:0] px_q[$];
	int               num_errors = 0;
	int               checks_done = 0;
	int               cyc = 0;
	logic [15:0]      setup [9] = '{{IDX_ROW_FIRST, 8'h00}, {IDX_ROW_SECOND, 8'h03},
		{IDX_X_HIGH, 8'h00}, {IDX_X_LOW, 8'h64}, {IDX_Y_LOW, 8'h32}, {IDX_X_OFFSET, 8'h00},
		{IDX_Y_OFFSET, 8'h00}, {IDX_Y_HIGH, 8'h00}, {IDX_MODE, 8'h01}};
	cursor_if link ();
	cursor_host cursor_host_inst (.CLK(clk), .ARST_N(arst_n), .DEV(link),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	cursor_overlay cursor_overlay_inst (.CLK(clk), .ARST_N(arst_n), .HOST(link),
		.ENHANCED_MODE(enh), .FOUR_PLANE_CFG(2'h0), .LINE_START(line_start), .RASTER_X(rx),
		.RASTER_Y(ry), .PIX_VALID(pix_valid), .PIX_IN(pix_in), .PIX_OUT_VALID(pix_out_valid),
		.PIX_OUT(pix_out), .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_ACK(mem_ack),
		.MEM_DATA(mem_data), .CURSOR_ACTIVE(cur_act));
	cursor_overlay_checker cursor_overlay_checker_inst (.CLK(clk), .ARST_N(arst_n),
		.io_stb(link.io_stb), .io_port(link.io_port), .io_ack(link.io_ack),
		.ENHANCED_MODE(enh), .PIX_VALID(pix_valid), .PIX_IN(pix_in),
		.PIX_OUT_VALID(pix_out_valid), .PIX_OUT(pix_out), .CURSOR_ACTIVE(cur_act),
		.MEM_REQ(mem_req), .MEM_ACK(mem_ack));
	initial begin
		forever #2 clk = ~clk;
	end
	// ----
	// memory answers one word every second cycle while requested; bus shows garbage between words
	// ----
	always @(posedge clk) begin
		mem_ack <= mem_req && !mem_ack;
		mem_data <= (mem_req && !mem_ack) ? mem_word : ~mem_data;
	end
	// ----
	// checking and closing
	// ----
	task automatic cmp(input logic [35:0] g, input logic [35:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		if (rvalid && rready) begin
			re = rd_q.pop_front();
			cmp({rresp, re[34] ? rdata : re[31:0]}, re[33:0]);
		end
		if (pix_out_valid) cmp(pix_out, px_q.size() ? px_q.pop_front() : ~pix_out);
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			close_out;
		end
	end
	// ----
	// bus tasks
	// ----
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && awready) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] a, input logic c, input logic [1:0] r,
		input logic [31:0] e, output logic [31:0] d);
		rd_q.push_back({c, r, e});
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		rready <= 1'b0;
	endtask : axi_rd
	task automatic idle;
		do axi_rd(AXI_STATUS, 1'b0, RESP_OKAY, '0, s); while (s[0] !== 1'b0);
	endtask : idle
	task automatic reg_wr(input logic [7:0] i, input logic [7:0] v);
		axi_wr(AXI_CMD, {15'h0, 1'b1, v, i});
		idle;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] i, input logic [7:0] v);
		axi_wr(AXI_CMD, {24'h0, i});
		idle;
		axi_rd(AXI_RDATA, 1'b1, RESP_OKAY, {24'h0, v}, s);
	endtask : reg_rd
	// one raster line at row 60; cursor spans lo..lo+63 (lo..lo+127 with use_c), inverted when inv is set
	task automatic run_line(input int lo, input logic inv, input logic use_c = 1'b0,
		input logic [PIX_W-1:0] c = '0);
		logic [PIX_W-1:0] p;
		@(posedge clk);
		ry <= 11'd60;
		line_start <= 1'b1;
		@(posedge clk);
		line_start <= 1'b0;
		repeat (1200) @(posedge clk);
		for (int x = 90; x < 176; x++) begin
			p = PIX_W'($urandom);
			// zoom 2 doubles the span, so the whole tail of the line is cursor
			px_q.push_back((x >= lo && x <= lo + (use_c ? 127 : 63)) ?
				(use_c ? c : (inv ? ~p : p)) : p);
			@(posedge clk);
			rx <= 11'(x);
			pix_in <= p;
			pix_valid <= 1'b1;
		end
		@(posedge clk);
		pix_valid <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : run_line
	// ----
	// main sequence
	// ----
	initial begin
		void'($urandom(32'he8576475));
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		reg_rd(IDX_FG_COLOR, RESET_BYTE);
		reg_wr(IDX_UNLOCK, UNLOCK_KEY);
		reg_wr(IDX_FG_COLOR, 8'h3c);
		reg_wr(IDX_BG_COLOR, 8'hc3);
		reg_rd(IDX_FG_COLOR, 8'h3c);
		reg_rd(IDX_BG_COLOR, 8'hc3);
		reg_wr(IDX_UNLOCK, LOCK_KEY);
		reg_wr(IDX_FG_COLOR, 8'h55);
		reg_rd(IDX_FG_COLOR, 8'h3c);
		axi_rd(32'h10, 1'b0, RESP_SLVERR, '0, s);
		$display("test registers finished");
		reg_wr(IDX_UNLOCK, UNLOCK_KEY);
		foreach (setup[i]) reg_wr(setup[i][15:8], setup[i][7:0]);
		mem_word <= 16'hffff;
		run_line(100, 1'b1);
		reg_rd(IDX_MODE, 8'h01);
		reg_wr(IDX_FG_STACK, 8'h11);
		reg_wr(IDX_FG_STACK, 8'h22);
		reg_wr(IDX_FG_STACK, 8'h33);
		reg_rd(IDX_FG_STACK, 8'h33);
		reg_rd(IDX_MODE, 8'h01);
		reg_rd(IDX_FG_STACK, 8'h11);
		reg_wr(IDX_FG_STACK, 8'h11);
		reg_wr(IDX_FG_STACK, 8'h22);
		reg_wr(IDX_MODE, 8'h07);
		run_line(100, 1'b0, 1'b1, 24'h332211);
		reg_wr(IDX_MODE, 8'h01);
		$display("test invert finished");
		reg_wr(IDX_X_LOW, 8'h14);
		run_line(100, 1'b1);
		reg_wr(IDX_Y_HIGH, 8'h00);
		run_line(20, 1'b1);
		$display("test commit finished");
		reg_wr(IDX_X_LOW, 8'h64);
		reg_wr(IDX_Y_HIGH, 8'h00);
		reg_wr(IDX_MODE, 8'h03);
		mem_word <= 16'h0000;
		run_line(100, 1'b0);
		reg_wr(IDX_MODE, 8'h00);
		mem_word <= 16'hffff;
		run_line(100, 1'b0);
		reg_wr(IDX_MODE, 8'h01);
		enh <= 1'b0;
		run_line(100, 1'b0);
		$display("test modes finished");
		close_out;
	end
endmodule : hardware_cursor_overlay_tb
`default_nettype wire
